// ==== core/cbda_pkg.sv ====
// Purpose: shared constants, types and helpers for the compare, branch and decimal adjust unit
// Assumes: one 125 MHz clock (8 ns period), synchronous active-high reset
// Notes: registers are word aligned on the Avalon-MM slave, with data in the low lanes (8 bits, 16 for the pc)
package cbda_pkg;

   // register byte offsets
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_DST = 8'h08;
   localparam logic [7:0] REG_SRC = 8'h0c;
   localparam logic [7:0] REG_PTR = 8'h10;
   localparam logic [7:0] REG_OFFSET = 8'h14;
   localparam logic [7:0] REG_PC = 8'h18;
   localparam logic [7:0] REG_FLAGS = 8'h1c;
   localparam logic [7:0] REG_CYCLES = 8'h20;

   // status bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_BAD = 2;
   localparam int ST_TAKEN = 3;

   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_PC = 16'h0000;

   // opcodes
   localparam logic [7:0] OP_CMP_RR = 8'ha2;
   localparam logic [7:0] OP_CMP_RIR = 8'ha3;
   localparam logic [7:0] OP_CMP_RR_LONG = 8'ha4;
   localparam logic [7:0] OP_CMP_RIR_LONG = 8'ha5;
   localparam logic [7:0] OP_CMP_IMM = 8'ha6;
   localparam logic [7:0] OP_CMP_INC_JUMP_EQUAL = 8'hc2;
   localparam logic [7:0] OP_CMP_INC_JUMP_NOT_EQUAL = 8'hd2;
   localparam logic [7:0] OP_DEC_ADJ_R = 8'h40;
   localparam logic [7:0] OP_DEC_ADJ_IR = 8'h41;

   // cycle counts
   localparam logic [7:0] CYC_CMP_SHORT = 8'h06;
   localparam logic [7:0] CYC_CMP_LONG = 8'h0a;
   localparam logic [7:0] CYC_JUMP_TAKEN = 8'h12;
   localparam logic [7:0] CYC_JUMP_NOT_TAKEN = 8'h10;
   localparam logic [7:0] CYC_DEC_ADJ = 8'h06;
   localparam logic [7:0] CYC_NONE = 8'h00;
   localparam logic [7:0] CYC_ONE = 8'h01;

   // decimal adjust corrections
   localparam logic [7:0] ADJ_NONE = 8'h00;
   localparam logic [3:0] ADJ_NIBBLE_FIX = 4'h6;
   localparam logic [3:0] ADJ_NIBBLE_MAX = 4'h9;
   localparam logic [7:0] ADJ_SUB_06 = 8'hfa;
   localparam logic [7:0] ADJ_SUB_60 = 8'ha0;
   localparam logic [7:0] ADJ_SUB_66 = 8'h9a;

   typedef enum logic [1:0] {
      CBDA_IDLE = 2'b01,
      CBDA_EXEC = 2'b10
   } cbda_state_t;

   // carry at bit 7 down to half carry at bit 2
   typedef struct packed {
      logic c;
      logic z;
      logic s;
      logic v;
      logic d;
      logic h;
      logic [1:0] rsv;
   } cbda_flags_t;

   function automatic logic cbda_is_cmp(input logic [7:0] op);
      return (op == OP_CMP_RR) || (op == OP_CMP_RIR) || (op == OP_CMP_RR_LONG) ||
             (op == OP_CMP_RIR_LONG) || (op == OP_CMP_IMM);
   endfunction

   function automatic logic cbda_is_jump(input logic [7:0] op);
      return (op == OP_CMP_INC_JUMP_EQUAL) || (op == OP_CMP_INC_JUMP_NOT_EQUAL);
   endfunction

   function automatic logic cbda_is_adj(input logic [7:0] op);
      return (op == OP_DEC_ADJ_R) || (op == OP_DEC_ADJ_IR);
   endfunction

   function automatic logic cbda_taken(input logic [7:0] op, input logic eq);
      return ((op == OP_CMP_INC_JUMP_EQUAL) && eq) || ((op == OP_CMP_INC_JUMP_NOT_EQUAL) && !eq);
   endfunction

   // zero marks an opcode this unit does not execute
   function automatic logic [7:0] cbda_cycles(input logic [7:0] op, input logic eq);
      logic [7:0] n;
      n = CYC_NONE;
      if ((op == OP_CMP_RR) || (op == OP_CMP_RIR)) begin
         n = CYC_CMP_SHORT;
      end else if (cbda_is_cmp(op)) begin
         n = CYC_CMP_LONG;
      end else if (cbda_is_jump(op)) begin
         n = cbda_taken(op, eq) ? CYC_JUMP_TAKEN : CYC_JUMP_NOT_TAKEN;
      end else if (cbda_is_adj(op)) begin
         n = CYC_DEC_ADJ;
      end
      return n;
   endfunction

endpackage

// ==== core/cbda_bcd_fix.sv ====
// Purpose: decimal adjust correction and carry for one byte
// Assumes: flags hold the state left by the preceding add or subtract
// Notes: purely combinational; inputs that are not valid BCD give an unchecked result
`timescale 1ns/1ps
module cbda_bcd_fix import cbda_pkg::*; (
   // byte and flags before adjustment
   input wire logic [7:0] value,
   input wire cbda_flags_t flags_in,
   // adjusted byte and carry
   output logic [7:0] result,
   output logic carry_out
);

   wire [3:0] lo = value[3:0];
   wire [3:0] hi = value[7:4];
   // one compact form covers every valid add row; invalid rows are don't-care
   wire lo_fix = flags_in.h | (lo > ADJ_NIBBLE_MAX);
   wire hi_fix = flags_in.c | (hi > ADJ_NIBBLE_MAX) | ((hi == ADJ_NIBBLE_MAX) & (lo > ADJ_NIBBLE_MAX));
   wire [7:0] add_fix = {hi_fix ? ADJ_NIBBLE_FIX : 4'h0, lo_fix ? ADJ_NIBBLE_FIX : 4'h0};
   wire [7:0] sub_fix = flags_in.c ? (flags_in.h ? ADJ_SUB_66 : ADJ_SUB_60) :
                                     (flags_in.h ? ADJ_SUB_06 : ADJ_NONE);
   wire [7:0] fix = flags_in.d ? sub_fix : add_fix;

   assign result = value + fix;
   assign carry_out = flags_in.d ? flags_in.c : hi_fix;

endmodule

// ==== core/cbda_core.sv ====
// Purpose: executes compare, compare-increment-jump and decimal adjust over Avalon-MM
// Assumes: sequencer loads operands, offset and next-instruction pc, then writes the opcode
// Notes: operand registers are locked while busy so results see stable inputs
`timescale 1ns/1ps
module cbda_core import cbda_pkg::*; #(
   parameter int AV_ADDR_W = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [AV_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // execution state
   output logic exec_busy,
   output logic exec_done
);

   if (AV_ADDR_W < 8 || AV_ADDR_W > 32) begin : g_bad_addr_w
      $error("cbda_core: AV_ADDR_W must lie between 8 and 32");
   end

   cbda_state_t state_q, state_d;
   logic wait_q;
   logic [31:0] rdata_q;
   logic [7:0] op_q;
   logic [7:0] dst_q;
   logic [7:0] src_q;
   logic [7:0] ptr_q;
   logic [7:0] ofs_q;
   logic [15:0] pc_q;
   cbda_flags_t flags_q;
   logic done_q;
   logic bad_q;
   logic taken_q;
   logic [7:0] cnt_q;
   logic [7:0] span_q;
   logic [7:0] last_cyc_q;
   logic done_pulse_q;

   // bus decode
   wire req = avs_read | avs_write;
   wire take = req & ~wait_q;
   wire wr_take = take & avs_write;
   wire hi_zero = (avs_address >> 8) == '0;
   wire [7:0] low_addr = avs_address[7:0];
   wire sel_cmd = hi_zero & (low_addr == REG_CMD);
   wire sel_status = hi_zero & (low_addr == REG_STATUS);
   wire sel_dst = hi_zero & (low_addr == REG_DST);
   wire sel_src = hi_zero & (low_addr == REG_SRC);
   wire sel_ptr = hi_zero & (low_addr == REG_PTR);
   wire sel_ofs = hi_zero & (low_addr == REG_OFFSET);
   wire sel_pc = hi_zero & (low_addr == REG_PC);
   wire sel_flags = hi_zero & (low_addr == REG_FLAGS);
   wire sel_cycles = hi_zero & (low_addr == REG_CYCLES);
   wire be0 = avs_byteenable[0];
   wire be1 = avs_byteenable[1];
   wire busy = state_q[1]; // exec bit of the one-hot code, so exec_busy is a flop output
   // operands and flags may not move under a running instruction
   wire wr_open = wr_take & ~busy & be0;

   // datapath
   wire [8:0] diff = {1'b0, dst_q} - {1'b0, src_q};
   wire cmp_eq = (diff[7:0] == 8'h00);
   wire cmp_borrow = diff[8];
   wire cmp_ovf = (dst_q[7] ^ src_q[7]) & (dst_q[7] ^ diff[7]);
   wire [15:0] rel_ext = {{8{ofs_q[7]}}, ofs_q};
   wire [15:0] pc_jump = pc_q + rel_ext;
   wire [7:0] ptr_inc = ptr_q + 8'h01;
   wire [7:0] adj_res;
   wire adj_carry;

   cbda_bcd_fix u_bcd_fix (
      .value(dst_q),
      .flags_in(flags_q),
      .result(adj_res),
      .carry_out(adj_carry)
   );

   // command start
   wire [7:0] new_op = avs_writedata[7:0];
   wire [7:0] new_cyc = cbda_cycles(new_op, cmp_eq);
   wire cmd_wr = wr_take & sel_cmd & be0;
   wire start = cmd_wr & ~busy & (new_cyc != CYC_NONE);
   wire refuse = cmd_wr & (busy | (new_cyc == CYC_NONE));
   wire commit = busy & (cnt_q == CYC_NONE);
   wire op_cmp = cbda_is_cmp(op_q);
   wire op_jump = cbda_is_jump(op_q);
   wire op_adj = cbda_is_adj(op_q);
   wire jump_now = cbda_taken(op_q, cmp_eq);
   wire clr_done = wr_take & sel_status & be0 & avs_writedata[ST_DONE];
   wire clr_bad = wr_take & sel_status & be0 & avs_writedata[ST_BAD];

   // next flags per operation
   cbda_flags_t cmp_flags, adj_flags, wr_flags;
   always_comb begin
      cmp_flags = flags_q;
      cmp_flags.c = cmp_borrow;
      cmp_flags.z = cmp_eq;
      cmp_flags.s = diff[7];
      cmp_flags.v = cmp_ovf;
      adj_flags = flags_q;
      adj_flags.c = adj_carry;
      adj_flags.z = (adj_res == 8'h00);
      adj_flags.s = adj_res[7];
      wr_flags = cbda_flags_t'(avs_writedata[7:0]);
      wr_flags.rsv = 2'b00;
   end

   // read mux
   wire [7:0] status_byte = {4'h0, taken_q, bad_q, done_q, busy};
   wire [31:0] rd_mux = sel_cmd ? {24'h0, op_q} :
                        sel_status ? {24'h0, status_byte} :
                        sel_dst ? {24'h0, dst_q} :
                        sel_src ? {24'h0, src_q} :
                        sel_ptr ? {24'h0, ptr_q} :
                        sel_ofs ? {24'h0, ofs_q} :
                        sel_pc ? {16'h0, pc_q} :
                        sel_flags ? {24'h0, flags_q} :
                        sel_cycles ? {24'h0, last_cyc_q} : 32'h0;

   always_comb begin
      state_d = state_q;
      case (state_q)
         CBDA_IDLE: begin
            if (start) begin
               state_d = CBDA_EXEC;
            end
         end
         CBDA_EXEC: begin
            if (commit) begin
               state_d = CBDA_IDLE;
            end
         end
         default: begin
            state_d = CBDA_IDLE;
         end
      endcase
   end

   // bus handshake: one wait cycle, then the answer
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0;
      end else begin
         wait_q <= ~(req & wait_q);
         if (req & wait_q) begin
            rdata_q <= avs_read ? rd_mux : 32'h0;
         end
      end
   end

   // sequencing
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= CBDA_IDLE;
         op_q <= RST_BYTE;
         cnt_q <= CYC_NONE;
         span_q <= CYC_NONE;
         last_cyc_q <= CYC_NONE;
         done_pulse_q <= 1'b0;
      end else begin
         state_q <= state_d;
         done_pulse_q <= commit;
         if (start) begin
            op_q <= new_op;
            cnt_q <= new_cyc - CYC_ONE;
            span_q <= CYC_NONE;
         end else if (busy) begin
            cnt_q <= cnt_q - CYC_ONE;
            span_q <= span_q + CYC_ONE;
         end
         if (commit) begin
            last_cyc_q <= span_q + CYC_ONE;
         end
      end
   end

   // sticky done and bad, set wins over clear; taken is reloaded at every commit
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         done_q <= 1'b0;
         bad_q <= 1'b0;
         taken_q <= 1'b0;
      end else begin
         done_q <= commit | (done_q & ~clr_done);
         bad_q <= refuse | (bad_q & ~clr_bad);
         if (commit) begin
            taken_q <= op_jump & jump_now;
         end
      end
   end

   // operand registers; dst is written back only by decimal adjust
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dst_q <= RST_BYTE;
         src_q <= RST_BYTE;
         ptr_q <= RST_BYTE;
         ofs_q <= RST_BYTE;
      end else begin
         if (commit & op_adj) begin
            dst_q <= adj_res;
         end else if (wr_open & sel_dst) begin
            dst_q <= avs_writedata[7:0];
         end
         if (wr_open & sel_src) begin
            src_q <= avs_writedata[7:0];
         end
         if (commit & op_jump) begin
            ptr_q <= ptr_inc;
         end else if (wr_open & sel_ptr) begin
            ptr_q <= avs_writedata[7:0];
         end
         if (wr_open & sel_ofs) begin
            ofs_q <= avs_writedata[7:0];
         end
      end
   end

   // pc and flags
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pc_q <= RST_PC;
         flags_q <= '0;
      end else begin
         if (commit & op_jump & jump_now) begin
            pc_q <= pc_jump;
         end else if (wr_take & ~busy & sel_pc) begin
            pc_q <= {be1 ? avs_writedata[15:8] : pc_q[15:8], be0 ? avs_writedata[7:0] : pc_q[7:0]};
         end
         // jump forms never reach this update
         if (commit & op_cmp) begin
            flags_q <= cmp_flags;
         end else if (commit & op_adj) begin
            flags_q <= adj_flags;
         end else if (wr_open & sel_flags) begin
            flags_q <= wr_flags;
         end
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign exec_busy = busy;
   assign exec_done = done_pulse_q;

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   property p_cmp_no_write;
      commit && !op_adj |=> dst_q == $past(dst_q);
   endproperty
   a_cmp_no_write: assert property (p_cmp_no_write) else $error("compare wrote an operand");

   property p_cmp_carry;
      commit && op_cmp |=> flags_q.c == ($past(src_q) > $past(dst_q));
   endproperty
   a_cmp_carry: assert property (p_cmp_carry) else $error("compare carry is not the borrow");

   property p_cmp_zsv;
      commit && op_cmp |=> flags_q.z == ($past(dst_q) == $past(src_q)) &&
         flags_q.s == (($past(dst_q) - $past(src_q)) >= 8'h80) &&
         flags_q.v == (($past(dst_q[7]) != $past(src_q[7])) && (flags_q.s != $past(dst_q[7]))) &&
         flags_q.d == $past(flags_q.d) && flags_q.h == $past(flags_q.h);
   endproperty
   a_cmp_zsv: assert property (p_cmp_zsv) else $error("compare flags wrong");

   property p_jump_eq;
      commit && op_q == OP_CMP_INC_JUMP_EQUAL |=> pc_q == ($past(cmp_eq) ? $past(pc_jump) : $past(pc_q));
   endproperty
   a_jump_eq: assert property (p_jump_eq) else $error("jump-equal pc wrong");

   property p_jump_ne;
      commit && op_q == OP_CMP_INC_JUMP_NOT_EQUAL |=> pc_q == ($past(cmp_eq) ? $past(pc_q) : $past(pc_jump));
   endproperty
   a_jump_ne: assert property (p_jump_ne) else $error("jump-not-equal pc wrong");

   property p_ptr_inc;
      commit && op_jump |=> ptr_q == $past(ptr_q) + 8'h01 && !busy;
   endproperty
   a_ptr_inc: assert property (p_ptr_inc) else $error("source pointer not incremented");

   property p_jump_cycles;
      commit && op_jump |=> last_cyc_q == ($past(jump_now) ? CYC_JUMP_TAKEN : CYC_JUMP_NOT_TAKEN);
   endproperty
   a_jump_cycles: assert property (p_jump_cycles) else $error("jump cycle count wrong");

   property p_rel_range;
      commit && op_jump && jump_now |=> ($signed(pc_q - $past(pc_q)) <= 16'sd127) &&
         ($signed(pc_q - $past(pc_q)) >= -16'sd128);
   endproperty
   a_rel_range: assert property (p_rel_range) else $error("jump target out of range");

   property p_jump_flags;
      commit && op_jump |=> $stable(flags_q);
   endproperty
   a_jump_flags: assert property (p_jump_flags) else $error("jump changed flags");

   property p_adj_time;
      start && cbda_is_adj(new_op) |=> busy [*6] ##1 !busy;
   endproperty
   a_adj_time: assert property (p_adj_time) else $error("decimal adjust not six cycles");

   property p_adj_sub_carry;
      commit && op_adj && flags_q.d |=> flags_q.c == $past(flags_q.c);
   endproperty
   a_adj_sub_carry: assert property (p_adj_sub_carry) else $error("subtract adjust carry moved");

   property p_adj_flags;
      commit && op_adj |=> flags_q.z == (dst_q == 8'h00) && flags_q.s == dst_q[7] &&
         $stable(flags_q.d) && $stable(flags_q.h);
   endproperty
   a_adj_flags: assert property (p_adj_flags) else $error("decimal adjust flags wrong");

   property p_adj_add_carry;
      commit && op_adj && !flags_q.d |=> flags_q.c == (($past(dst_q) - dst_q) != 8'h00 &&
         (dst_q - $past(dst_q)) >= 8'h60);
   endproperty
   a_adj_add_carry: assert property (p_adj_add_carry) else $error("add adjust carry wrong");

   property p_bus_answer;
      req && wait_q |=> !wait_q;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

   c_cmp: cover property (commit && op_cmp && cmp_borrow);
   c_jump_eq_taken: cover property (commit && op_q == OP_CMP_INC_JUMP_EQUAL && cmp_eq);
   c_jump_ne_fall: cover property (commit && op_q == OP_CMP_INC_JUMP_NOT_EQUAL && cmp_eq);
   c_adj_sub: cover property (commit && op_adj && flags_q.d && flags_q.c);

endmodule

// ==== tb/cbda_seq_model.sv ====
// Purpose: sequencer model that loads operands and issues opcodes over avalon-mm
// Assumes: slave answers by dropping waitrequest; the master waits as long as it is asked
// Notes: stall adds idle cycles before a request; released address and data lines carry inverted values
`timescale 1ns/1ps
module cbda_seq_model import cbda_pkg::*; (
   // clock
   input wire logic sys_clk,
   // avalon-mm master
   output logic [7:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   int stall = 0;
   initial begin
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
   end
   // no limit of its own: only the bench watchdog may end a wait
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      repeat (stall + 1) @(posedge sys_clk);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= wd;
      avs_byteenable <= 4'hf;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge sys_clk);
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_address <= ~a;
      avs_writedata <= ~wd;
      avs_byteenable <= 4'h0;
   endtask
endmodule

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for compare, compare-increment-jump and decimal adjust
// Assumes: sequencer model drives the register bus; expectations are hand-derived
// Notes: busy cycles are counted at the port, independent of the cycles register
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_top import cbda_pkg::*; ;
   logic sys_clk;
   logic rst;
   logic [7:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic exec_busy;
   logic exec_done;
   int bad_count = 0;
   int n_tests = 0;
   logic [31:0] r;
   logic [7:0] d;
   logic [7:0] s;
   logic [7:0] f;
   logic tk;
   logic [15:0] pc;
   logic [7:0] cmp_op [5] = '{OP_CMP_RR, OP_CMP_RIR, OP_CMP_RR_LONG, OP_CMP_RIR_LONG, OP_CMP_IMM};
   logic [7:0] cmp_d [5] = '{8'h02, 8'h05, 8'h80, 8'h7f, 8'h33};
   logic [7:0] cmp_s [5] = '{8'h03, 8'h0a, 8'h01, 8'hff, 8'h33};
   logic [7:0] j_op [4] = '{OP_CMP_INC_JUMP_EQUAL, OP_CMP_INC_JUMP_EQUAL, OP_CMP_INC_JUMP_NOT_EQUAL,
                            OP_CMP_INC_JUMP_NOT_EQUAL};
   logic [7:0] j_d [4] = '{8'h02, 8'h02, 8'h02, 8'h55};
   logic [7:0] j_s [4] = '{8'h02, 8'h03, 8'h04, 8'h55};
   logic [7:0] j_off [4] = '{8'h80, 8'h10, 8'h7f, 8'h10};
   logic [7:0] j_ptr [4] = '{8'h03, 8'hff, 8'h03, 8'h7f};
   logic [15:0] j_pc [4] = '{16'h0040, 16'h1000, 16'h1000, 16'h2000};
   // byte, flags before, byte after, flags after
   logic [7:0] adj_v [8] = '{8'h3c, 8'h9a, 8'h12, 8'hb5, 8'h31, 8'h2f, 8'h91, 8'hff};
   logic [7:0] adj_f [8] = '{8'h40, 8'h10, 8'h84, 8'h20, 8'h08, 8'h0c, 8'h88, 8'h8c};
   logic [7:0] adj_r [8] = '{8'h42, 8'h00, 8'h78, 8'h15, 8'h31, 8'h29, 8'h31, 8'h99};
   logic [7:0] adj_g [8] = '{8'h00, 8'hd0, 8'h84, 8'h80, 8'h08, 8'h0c, 8'h88, 8'hac};

   always #4 sys_clk = ~sys_clk;

   cbda_seq_model u_seq (
      .sys_clk(sys_clk),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest)
   );

   cbda_core #(.AV_ADDR_W(8)) DUT (
      .sys_clk(sys_clk),
      .rst(rst),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .exec_busy(exec_busy),
      .exec_done(exec_done)
   );

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] x;
      u_seq.xfer(1'b1, a, v, x);
   endtask

   task automatic chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      u_seq.xfer(1'b0, a, 32'h0, x);
      `CHK(x, e)
   endtask

   // length is counted from busy at the port, then read back
   task automatic run(input logic [7:0] op, input int n_exp);
      int n;
      logic seen;
      n = 0;
      seen = 1'b0;
      wr(REG_CMD, {24'h0, op});
      for (int i = 0; i < 40; i++) begin
         @(posedge sys_clk);
         if (exec_done === 1'b1) begin
            seen = 1'b1;
            break;
         end
         if (exec_busy === 1'b1) n++;
      end
      `CHK(seen, 1'b1)
      `CHK(n, n_exp)
      chk(REG_CYCLES, n_exp);
   endtask

   task automatic results;
      $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      #200000;
      bad_count++;
      results();
   end

   initial begin
      sys_clk = 1'b0;
      rst = 1'b1;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      chk(REG_FLAGS, 32'h0);
      chk(8'h80, 32'h0);
      for (int i = 0; i < 5; i++) begin
         d = cmp_d[i];
         s = cmp_s[i];
         f = i[0] ? 8'h0c : 8'hf0;
         wr(REG_FLAGS, {24'h0, f});
         wr(REG_DST, {24'h0, d});
         wr(REG_SRC, {24'h0, s});
         run(cmp_op[i], (i < 2) ? 6 : 10);
         r[7:0] = d - s;
         chk(REG_FLAGS, {24'h0, s > d, r[7:0] == 8'h00, r[7], (d[7] != s[7]) && (r[7] != d[7]), f[3:2], 2'b00});
         chk(REG_DST, {24'h0, d});
         chk(REG_SRC, {24'h0, s});
      end
      for (int i = 0; i < 4; i++) begin
         f = i[0] ? 8'h54 : 8'ha8;
         tk = (j_d[i] == j_s[i]) ^ (j_op[i] == OP_CMP_INC_JUMP_NOT_EQUAL);
         pc = tk ? j_pc[i] + {{8{j_off[i][7]}}, j_off[i]} : j_pc[i];
         wr(REG_FLAGS, {24'h0, f});
         wr(REG_DST, {24'h0, j_d[i]});
         wr(REG_SRC, {24'h0, j_s[i]});
         wr(REG_PTR, {24'h0, j_ptr[i]});
         wr(REG_OFFSET, {24'h0, j_off[i]});
         wr(REG_PC, {16'h0, j_pc[i]});
         run(j_op[i], tk ? 18 : 16);
         chk(REG_PC, {16'h0, pc});
         chk(REG_PTR, {24'h0, j_ptr[i] + 8'h01});
         chk(REG_FLAGS, {24'h0, f});
         chk(REG_STATUS, {28'h0, tk, 3'b010});
         wr(REG_STATUS, 32'h6);
      end
      u_seq.stall = 2;
      for (int i = 0; i < 8; i++) begin
         wr(REG_FLAGS, {24'h0, adj_f[i]});
         wr(REG_DST, {24'h0, adj_v[i]});
         run(i[0] ? OP_DEC_ADJ_IR : OP_DEC_ADJ_R, 6);
         chk(REG_DST, {24'h0, adj_r[i]});
         chk(REG_FLAGS, {24'h0, adj_g[i]});
      end
      u_seq.stall = 0;
      wr(REG_CMD, 32'hff);
      chk(REG_STATUS, {28'h0, 4'b0110});
      results();
   end
endmodule
